// [hw/holding_regs.sv]
// eight byte holding registers with registered read port
`include "table_write_op_test_zero_skip_op_regs.svh"
module holding_regs (
	input  wire logic       i_core_clk,  // core clock
	input  wire logic       i_rst,       // sync reset
	input  wire logic       i_we,        // write strobe
	input  wire logic [2:0] i_wsel,      // write select
	input  wire logic [7:0] i_wdata,     // write byte
	input  wire logic [2:0] i_rsel,      // read select
	output logic      [7:0] o_rdata      // registered read byte
);
	logic [7:0] mem_r [0:7];
	logic [7:0] rdata_r;
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			for (int k = 0; k < `HOLD_COUNT; k++) begin
				mem_r[k] <= `HOLD_RST;
			end
			rdata_r <= `HOLD_RST;
		end else begin
			if (i_we) begin
				mem_r[i_wsel] <= i_wdata;
			end
			rdata_r <= mem_r[i_rsel];
		end
	end
	assign o_rdata = rdata_r;
endmodule

// [hw/table_write_op_test_zero_skip_op.sv]
// table write and zero skip instruction decoder
`include "table_write_op_test_zero_skip_op_regs.svh"
module table_write_and_zero_skip
	import table_write_and_zero_skip_pkg::*;
(
	input  wire logic         i_core_clk,    // core clock, one instruction cycle per rising edge
	input  wire logic         i_rst,         // sync reset, active high
	input  wire logic         i_issue,       // instruction word valid for decode
	input  wire logic [15:0]  i_instr,       // instruction word
	input  wire logic         i_next_two,    // prefetched instruction is two words
	input  wire logic [7:0]   i_table_latch, // table latch byte
	input  wire logic [7:0]   i_operand,     // register value fetched at o_data_addr
	input  wire logic         i_ext_set,     // extended instruction set enabled
	input  wire logic [3:0]   i_bank_sel,    // bank select register
	input  wire logic [11:0]  i_index_base,  // index register used for literal offset
	input  wire logic         i_ptr_load,    // load table pointer
	input  wire logic [20:0]  i_ptr_data,    // table pointer load value
	input  wire logic [2:0]   i_hold_rsel,   // holding register read select
	output logic              o_busy,        // instruction still executing
	output logic              o_squash,      // prefetched word is discarded
	output logic              o_skip_taken,  // zero skip happened
	output logic [20:0]       o_table_pointer, // table pointer
	output logic              o_high_byte,   // addressed byte is high byte
	output logic [11:0]       o_data_addr,   // resolved operand address
	output logic [7:0]        o_hold_rdata   // holding register read data
);
	exec_state_t                 st_r, st_nxt;
	logic [`PTR_W-1:0]           ptr_r, ptr_nxt;
	logic [`HOLD_SEL_W-1:0]      wsel_r, wsel_nxt;
	logic                        we_r, we_nxt;
	logic                        busy_r, busy_nxt;
	logic                        squash_r, squash_nxt;
	logic                        skip_r, skip_nxt;
	logic [11:0]                 addr_r, addr_nxt;
	logic                        is_tw, is_tz, bank_bit;
	logic [7:0]                  fld;
	ptr_mode_t                   mode;

	assign is_tw    = i_issue && (st_r == ST_IDLE) && (i_instr[15:2] == `TW_OPC_HI);
	assign is_tz    = i_issue && (st_r == ST_IDLE) && (i_instr[15:9] == `TZ_OPC_HI);
	assign mode     = ptr_mode_t'(i_instr[1:0]);
	assign bank_bit = i_instr[8];
	assign fld      = i_instr[7:0];

	// operand address: access bank, bank select, or indexed literal offset
	always_comb begin
		addr_nxt = addr_r;
		if (is_tz) begin
			if (bank_bit) begin
				addr_nxt = {i_bank_sel, fld};
			end else if (i_ext_set && fld <= `ILO_LIMIT) begin
				addr_nxt = i_index_base + {4'h0, fld};
			end else if (fld >= `ACCESS_HI_BASE) begin
				addr_nxt = {`ACCESS_HI_BANK, fld};
			end else begin
				addr_nxt = {`ACCESS_LO_BANK, fld};
			end
		end
	end

	// sequencing and pointer update
	always_comb begin
		st_nxt     = st_r;
		ptr_nxt    = ptr_r;
		wsel_nxt   = wsel_r;
		we_nxt     = 1'b0;
		busy_nxt   = 1'b0;
		squash_nxt = 1'b0;
		skip_nxt   = 1'b0;
		if (i_ptr_load) begin
			ptr_nxt = i_ptr_data;
		end
		case (st_r)
			ST_IDLE: begin
				if (is_tw) begin
					busy_nxt = 1'b1;
					st_nxt   = ST_TW_WRITE;
					case (mode)
						PTR_PRE_INC: begin
							ptr_nxt  = ptr_r + 21'h00_0001;
							wsel_nxt = ptr_nxt[2:0];
						end
						PTR_POST_INC: begin
							wsel_nxt = ptr_r[2:0];
							ptr_nxt  = ptr_r + 21'h00_0001;
						end
						PTR_POST_DEC: begin
							wsel_nxt = ptr_r[2:0];
							ptr_nxt  = ptr_r - 21'h00_0001;
						end
						default: begin
							ptr_nxt  = ptr_r; // a same-cycle load loses to the write
							wsel_nxt = ptr_r[2:0];
						end
					endcase
				end else if (is_tz && i_operand == 8'h00) begin
					busy_nxt   = 1'b1;
					squash_nxt = 1'b1;
					skip_nxt   = 1'b1;
					st_nxt     = i_next_two ? ST_SKIP2 : ST_SKIP1;
				end
				// a nonzero test finishes here with no state change
			end
			ST_TW_WRITE: begin
				we_nxt = 1'b1;
				st_nxt = ST_IDLE;
			end
			ST_SKIP2: begin
				busy_nxt   = 1'b1;
				squash_nxt = 1'b1;
				st_nxt     = ST_SKIP1;
			end
			ST_SKIP1: begin
				st_nxt = ST_IDLE;
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st_r     <= ST_IDLE;
			ptr_r    <= `PTR_RST;
			wsel_r   <= 3'h0;
			we_r     <= 1'b0;
			busy_r   <= 1'b0;
			squash_r <= 1'b0;
			skip_r   <= 1'b0;
			addr_r   <= 12'h000;
		end else begin
			st_r     <= st_nxt;
			ptr_r    <= ptr_nxt;
			wsel_r   <= wsel_nxt;
			we_r     <= we_nxt;
			busy_r   <= busy_nxt;
			squash_r <= squash_nxt;
			skip_r   <= skip_nxt;
			addr_r   <= addr_nxt;
		end
	end

	// table latch byte lands in the holding register chosen at decode
	holding_regs u_hold (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_we       (we_nxt),
		.i_wsel     (wsel_r),
		.i_wdata    (i_table_latch),
		.i_rsel     (i_hold_rsel),
		.o_rdata    (o_hold_rdata)
	);

	assign o_busy          = busy_r;
	assign o_squash        = squash_r;
	assign o_skip_taken    = skip_r;
	assign o_table_pointer = ptr_r;
	assign o_high_byte     = ptr_r[0];
	assign o_data_addr     = addr_r;

	// pointer moves as the variant asks; select uses old or new low bits
	post_inc_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(is_tw && mode == PTR_POST_INC && !i_ptr_load)
		|=> (ptr_r == $past(ptr_r) + 21'h00_0001 && wsel_r == $past(ptr_r[2:0])))
		else $error("post increment wrong");
	pre_inc_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(is_tw && mode == PTR_PRE_INC)
		|=> (ptr_r == $past(ptr_r) + 21'h00_0001 && wsel_r == ptr_r[2:0]))
		else $error("pre increment select wrong");
	keep_ptr_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(is_tw && mode == PTR_KEEP) |=> $stable(ptr_r))
		else $error("pointer moved");
	high_byte_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		is_tw |=> (o_high_byte == ($past(ptr_r[0]) ^ ($past(mode) != PTR_KEEP))))
		else $error("byte select wrong");

	// latch byte lands in the second cycle, then new work is taken
	tw_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		is_tw |=> (st_r == ST_TW_WRITE && we_nxt) ##1 (st_r == ST_IDLE))
		else $error("write cycle missing");
	tw_busy_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		is_tw |=> o_busy ##1 !o_busy)
		else $error("write busy wrong");
	hold_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		we_r |-> (u_hold.mem_r[$past(wsel_r)] == $past(i_table_latch)))
		else $error("holding write wrong");

	// a zero operand squashes one or two prefetched words
	skip_one_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(is_tz && i_operand == 8'h00 && !i_next_two)
		|=> o_squash ##1 (!o_squash && st_r == ST_IDLE))
		else $error("single skip wrong");
	skip_two_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(is_tz && i_operand == 8'h00 && i_next_two)
		|=> o_squash [*2] ##1 (!o_squash && st_r == ST_IDLE))
		else $error("double skip wrong");
	skip_flag_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(is_tz && i_operand == 8'h00) |=> o_skip_taken ##1 !o_skip_taken)
		else $error("skip flag wrong");
	no_skip_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(is_tz && i_operand != 8'h00) |=> (!o_busy && !o_squash))
		else $error("nonzero skipped");

	// operand address of the zero test
	bank_sel_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(is_tz && bank_bit) |=> (o_data_addr == {$past(i_bank_sel), $past(fld)}))
		else $error("bank address wrong");
	index_mode_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(is_tz && !bank_bit && i_ext_set && fld <= `ILO_LIMIT)
		|=> (o_data_addr == $past(i_index_base) + {4'h0, $past(fld)}))
		else $error("indexed address wrong");
	access_bank_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(is_tz && !bank_bit && !(i_ext_set && fld <= `ILO_LIMIT))
		|=> (o_data_addr == {(($past(fld) >= `ACCESS_HI_BASE) ? `ACCESS_HI_BANK
			: `ACCESS_LO_BANK), $past(fld)}))
		else $error("access bank address wrong");
endmodule

// [hw/table_write_op_test_zero_skip_op_pkg.sv]
// types for the table write and zero skip decoder
package table_write_and_zero_skip_pkg;
	typedef enum logic [1:0] {
		PTR_KEEP,
		PTR_POST_INC,
		PTR_POST_DEC,
		PTR_PRE_INC
	} ptr_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_TW_WRITE,
		ST_SKIP1,
		ST_SKIP2
	} exec_state_t;
endpackage

// [hw/table_write_op_test_zero_skip_op_regs.svh]
// constants for the table write and zero skip decoder
`ifndef TABLE_WRITE_ZERO_SKIP_REGS_SVH
`define TABLE_WRITE_ZERO_SKIP_REGS_SVH
`define PTR_W          21
`define PTR_RST        21'h00_0000
`define HOLD_SEL_W     3
`define HOLD_COUNT     8
`define HOLD_RST       8'hFF
`define TW_OPC_HI      14'h0003
`define TZ_OPC_HI      7'h33
`define ILO_LIMIT      8'h5F
`define ACCESS_HI_BASE 8'hF0
`define ACCESS_LO_BANK 4'h0
`define ACCESS_HI_BANK 4'hF
`endif

// [verif/hold_reader.sv]
// holding register reader standing in for the flash programming side
module hold_reader (
	input  wire logic       i_core_clk, // core clock
	input  wire logic [2:0] i_want,     // register to fetch
	output logic      [2:0] o_rsel,     // read select to block
	input  wire logic [7:0] i_rdata,    // registered read data
	output logic      [7:0] o_byte      // fetched byte
);
	timeunit 1ns;
	timeprecision 1ns;
	// select and data each pass one register, as the flash side would
	always @(posedge i_core_clk) begin
		o_rsel <= i_want;
		o_byte <= i_rdata;
	end
endmodule

// [verif/test_table_write_and_zero_skip.sv]
// bench for the table write and zero skip decoder
module test_table_write_and_zero_skip;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst = 1, issue = 0, next_two = 0, ext = 0, pload = 0;
	logic        busy, squash, skip_taken, high_byte;
	logic [15:0] instr = '0;
	logic [7:0]  latch = '0, operand = '0, hbyte, hold_rdata;
	logic [3:0]  bank = '0;
	logic [11:0] base = '0, daddr, data_addr;
	logic [20:0] pdata = '0, ptr, exp_ptr = '0;
	logic [2:0]  want = '0, rsel;
	logic [23:0] notes[$];
	int          err_total = 0, total_checks = 0, cyc = 0, seed = 38;

	table_write_and_zero_skip i_table_write_and_zero_skip (.i_core_clk(clk), .i_rst(rst),
		.i_issue(issue), .i_instr(instr), .i_next_two(next_two), .i_table_latch(latch),
		.i_operand(operand), .i_ext_set(ext), .i_bank_sel(bank), .i_index_base(base),
		.i_ptr_load(pload), .i_ptr_data(pdata), .i_hold_rsel(rsel), .o_busy(busy),
		.o_squash(squash), .o_skip_taken(skip_taken), .o_table_pointer(ptr),
		.o_high_byte(high_byte), .o_data_addr(data_addr), .o_hold_rdata(hold_rdata));
	hold_reader i_hold_reader (.i_core_clk(clk), .i_want(want), .o_rsel(rsel),
		.i_rdata(hold_rdata), .o_byte(hbyte));

	initial forever #10 clk = ~clk;

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// every busy or squash cycle must match the oldest note
	always @(negedge clk) if (!rst && (busy || squash)) begin
		if (notes.size() == 0)
			check({busy, squash, skip_taken, ptr}, 24'h00_0000);
		else
			check({busy, squash, skip_taken, ptr}, notes.pop_front());
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 1000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic tw(input logic [1:0] nn, input int k);
		logic [2:0] sel;
		pdata = (k == 0) ? 21'h1F_FFFF : 21'($random(seed));
		pload = 1;
		@(posedge clk);
		#2 pload = 0;
		exp_ptr = (nn == 2) ? pdata - 21'h1 : (nn == 0) ? pdata : pdata + 21'h1;
		sel = (nn == 3) ? exp_ptr[2:0] : pdata[2:0];
		instr = {14'h0003, nn};
		issue = 1;
		notes.push_back({3'b100, exp_ptr});
		@(posedge clk);
		#2 latch = 8'($random(seed));
		// issue held over the busy cycle must be ignored
		@(posedge clk);
		#2 issue = 0;
		want = sel;
		repeat (4) @(posedge clk);
		#2 check({16'h0, hbyte}, {16'h0, latch});
		check({23'h0, high_byte}, {23'h0, exp_ptr[0]});
	endtask

	// am picks the address path: 0 bank select, 1 indexed, 2 access high, 3 access low
	task automatic sk(input logic zero, input logic two, input logic [1:0] am);
		logic       a;
		logic [7:0] f;
		a = (am == 2'h0);
		f = 8'($random(seed));
		ext = (am == 2'h1) ? 1'b1 : 1'($random(seed));
		if (am == 2'h1)
			f = f & 8'h5F;
		else if (am == 2'h2)
			f = f | 8'hF0;
		else if (am == 2'h3)
			f = (f & 8'h0F) | 8'h60;
		bank = 4'($random(seed));
		base = 12'($random(seed));
		operand = zero ? 8'h00 : (8'($random(seed)) | 8'h01);
		next_two = two;
		instr = {7'h33, a, f};
		issue = 1;
		if (zero)
			notes.push_back({3'b111, exp_ptr});
		if (zero && two)
			notes.push_back({3'b110, exp_ptr});
		@(posedge clk);
		#2 issue = 0;
		daddr = a ? {bank, f} : (ext && f <= 8'h5F) ? base + 12'(f)
			: {(f >= 8'hF0) ? 4'hF : 4'h0, f};
		repeat (3) @(posedge clk);
		#2 check({12'h0, data_addr}, {12'h0, daddr});
	endtask

	initial begin
		repeat (10) @(posedge clk);
		#2 rst = 0;
		for (int k = 0; k < 8; k++)
			tw(k[1:0], k);
		$display("table write test done");
		for (int k = 0; k < 16; k++)
			sk(k[0], k[1], k[3:2]);
		$display("zero skip test done");
		check(24'(notes.size()), 24'h00_0000);
		tally_and_finish();
	end
endmodule
